// [hw/fault_stats_pkg.sv]
// How it works
// - OAM runs on the two fiber ports only; copper ports never join.
// - Each fiber port has a role: 0 disabled, 1 passive, 2 active.
// - The active end supplies OAM configuration; the passive end adopts it.
// - Both ends active: lower MAC address acts active, higher acts passive.
// - At most ten OAM frames per second leave any fiber port.
// - Each port has a selectable set of condition ports forcing it down.
// - AND row: forced down only while all selected ports lost link.
// - OR row: forced down while any selected port lost link.
// - One selected port gives the same result under AND or OR.
// - Matrix edits apply only on confirm; a reset action restores defaults.
// - Pass-through on and copper link lost: notify the selected remote.
// - With pass-through on, a notification received on an enabled fiber port disables the matching local copper port.
// - Pass-through select: 0 off, 1 fiber port 1 remote, 2 fiber port 2.
// - Pass-through and local matrix are mutually exclusive.
// - Each fiber port keeps its own 32-bit OAM frame counters.
// - Counters per OAM frame kind and direction, events, unsupported.
// - Each port has 64-bit receive and transmit counters, read live; a stats sample strobe pulses every 3 s.
// - OAM and per-port counters clear on request.
// - Address learning is on after reset and can be switched off.
// - Learned entries age out five to ten minutes after their last refresh.
// - Clear command removes dynamic entries but keeps static ones.
package fault_stats_pkg;

    // ****************************************************************
    // Sizes and encodings
    // ****************************************************************
    localparam int NUM_PORTS   = 4;
    localparam int NUM_FIBER   = 2;
    localparam int MAC_ENTRIES = 16;
    localparam int NUM_OAM_CNT = 16;

    localparam logic [1:0] ROLE_DISABLED = 2'h0;
    localparam logic [1:0] ROLE_PASSIVE  = 2'h1;
    localparam logic [1:0] ROLE_ACTIVE   = 2'h2;

    localparam logic [1:0] PASS_OFF    = 2'h0;
    localparam logic [1:0] PASS_FIBER1 = 2'h1;
    localparam logic [1:0] PASS_FIBER2 = 2'h2;

    // OAM frame kinds as seen on the frame event inputs.
    localparam logic [2:0] KIND_INFO     = 3'h0;
    localparam logic [2:0] KIND_EVENT    = 3'h1;
    localparam logic [2:0] KIND_LOOPBACK = 3'h2;
    localparam logic [2:0] KIND_VAR_REQ  = 3'h3;
    localparam logic [2:0] KIND_VAR_RSP  = 3'h4;
    localparam logic [2:0] KIND_VENDOR   = 3'h5;
    localparam logic [2:0] KIND_UNSUP    = 3'h6;

    // Counter slots inside each fiber port's bank.
    localparam logic [3:0] CNT_ALL_TX      = 4'h0;
    localparam logic [3:0] CNT_ALL_RX      = 4'h1;
    localparam logic [3:0] CNT_INFO_TX     = 4'h2;
    localparam logic [3:0] CNT_INFO_RX     = 4'h3;
    localparam logic [3:0] CNT_EVENT_TX    = 4'h4;
    localparam logic [3:0] CNT_UEVENT_RX   = 4'h5;
    localparam logic [3:0] CNT_DEVENT_RX   = 4'h6;
    localparam logic [3:0] CNT_LOOP_TX     = 4'h7;
    localparam logic [3:0] CNT_LOOP_RX     = 4'h8;
    localparam logic [3:0] CNT_VREQ_TX     = 4'h9;
    localparam logic [3:0] CNT_VREQ_RX     = 4'ha;
    localparam logic [3:0] CNT_VRSP_TX     = 4'hb;
    localparam logic [3:0] CNT_VRSP_RX     = 4'hc;
    localparam logic [3:0] CNT_VENDOR_TX   = 4'hd;
    localparam logic [3:0] CNT_VENDOR_RX   = 4'he;
    localparam logic [3:0] CNT_UNSUP_RX    = 4'hf;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [3:0] RST_MATRIX_SEL = 4'h0;
    localparam logic       RST_ROW_OR     = 1'b0;
    localparam logic       RST_LEARN_EN   = 1'b1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint CLK_HZ         = 200000000;
    localparam int     OAM_MIN_GAP_MS = 100;
    localparam int     AGE_TIME_S     = 300;
    localparam int     SAMPLE_S       = 3;
    localparam longint OAM_GAP_CYC    = CLK_HZ * OAM_MIN_GAP_MS / 1000;
    localparam longint SEC_CYC        = CLK_HZ;

endpackage

// [hw/link_fault_oam_stats.sv]
`timescale 1ns/10ps
`default_nettype none
module link_fault_oam_stats
    import fault_stats_pkg::*;
#(
    parameter int unsigned OAM_GAP = 32'(OAM_GAP_CYC),
    parameter int unsigned SEC     = 32'(SEC_CYC)
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_link_up,
    input  wire logic [3:0]  i_edit_sel_row,
    input  wire logic [3:0]  i_edit_sel,
    input  wire logic        i_edit_or,
    input  wire logic [1:0]  i_edit_row,
    input  wire logic        i_edit_we,
    input  wire logic        i_matrix_confirm,
    input  wire logic        i_matrix_reset,
    input  wire logic [1:0]  i_remote_pass_select,
    input  wire logic [1:0]  i_fiber_oam_role_0,
    input  wire logic [1:0]  i_fiber_oam_role_1,
    input  wire logic [47:0] i_local_mac,
    input  wire logic [1:0]  i_peer_active,
    input  wire logic [47:0] i_peer_mac_0,
    input  wire logic [47:0] i_peer_mac_1,
    input  wire logic [1:0]  i_oam_tx_req,
    input  wire logic [2:0]  i_oam_tx_kind,
    input  wire logic [1:0]  i_oam_rx,
    input  wire logic [2:0]  i_oam_rx_kind,
    input  wire logic        i_oam_rx_dup,
    input  wire logic [1:0]  i_pass_notify_rx,
    input  wire logic        i_pass_notify_port,
    input  wire logic [3:0]  i_frame_rx,
    input  wire logic [3:0]  i_frame_tx,
    input  wire logic        i_clear_counters,
    input  wire logic        i_learn_enable,
    input  wire logic        i_learn_req,
    input  wire logic [3:0]  i_learn_idx,
    input  wire logic        i_learn_static,
    input  wire logic        i_clear_dynamic,
    input  wire logic [0:0]  i_cnt_fiber,
    input  wire logic [3:0]  i_cnt_sel,
    input  wire logic [1:0]  i_port_sel,
    output logic      [3:0]  o_port_force_down,
    output logic      [1:0]  o_oam_tx_grant,
    output logic      [2:0]  o_oam_tx_kind,
    output logic      [1:0]  o_oam_act_active,
    output logic      [1:0]  o_adopt_peer_cfg,
    output logic      [1:0]  o_pass_notify_tx,
    output logic      [1:0]  o_pass_notify_port,
    output logic      [31:0] o_oam_count,
    output logic      [63:0] o_rx_count,
    output logic      [63:0] o_tx_count,
    output logic             o_stats_sample,
    output logic      [15:0] o_entry_valid,
    output logic      [15:0] o_entry_static,
    output logic             o_learn_enabled
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:0][3:0]  sel;
        logic [3:0]       row_or;
        logic [3:0][3:0]  edit_sel;
        logic [3:0]       edit_or;
        logic [3:0]       force_down;
        logic [1:0][31:0] gap;
        logic [1:0]       grant;
        logic [2:0]       tx_kind;
        logic [1:0]       act_active;
        logic [1:0]       adopt;
        logic [1:0]       copper_up_q;
        logic [1:0]       notify_tx;
        logic [1:0]       notify_port;
        logic [1:0]       remote_down;
        logic [31:0]      oam_count;
        logic [63:0]      rx_count;
        logic [63:0]      tx_count;
        logic [31:0]      sec_cnt;
        logic [1:0]       sample_sec;
        logic             sample;
        logic [8:0]       age_sec;
        logic             learn_en;
        logic [15:0]      valid;
        logic [15:0]      is_static;
        logic [15:0]      hit;
    } state_t;

    state_t st;
    state_t next_st;

    logic [1:0][15:0][31:0] oam_cnt;
    logic [3:0][63:0]       rx_cnt;
    logic [3:0][63:0]       tx_cnt;

    // ****************************************************************
    // Counter banks
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        for (int f = 0; f < NUM_FIBER; f++) begin
            for (int c = 0; c < NUM_OAM_CNT; c++) begin
                if (i_sys_rst || i_clear_counters) begin
                    oam_cnt[f][c] <= 32'h0;
                end else begin
                    oam_cnt[f][c] <= oam_cnt[f][c] + 32'(
                        (st.grant[f] && tx_slot(st.tx_kind) == 4'(c)) ||
                        (st.grant[f] && c == int'(CNT_ALL_TX)) ||
                        (i_oam_rx[f] && rx_slot(i_oam_rx_kind,
                            i_oam_rx_dup) == 4'(c)) ||
                        (i_oam_rx[f] && c == int'(CNT_ALL_RX)));
                end
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (i_sys_rst || i_clear_counters) begin
                rx_cnt[p] <= 64'h0;
                tx_cnt[p] <= 64'h0;
            end else begin
                rx_cnt[p] <= rx_cnt[p] + 64'(i_frame_rx[p]);
                tx_cnt[p] <= tx_cnt[p] + 64'(i_frame_tx[p] &&
                                              !st.force_down[p]);
            end
        end
    end

    function automatic logic [3:0] tx_slot(input logic [2:0] k);
        case (k)
            KIND_INFO:     tx_slot = CNT_INFO_TX;
            KIND_EVENT:    tx_slot = CNT_EVENT_TX;
            KIND_LOOPBACK: tx_slot = CNT_LOOP_TX;
            KIND_VAR_REQ:  tx_slot = CNT_VREQ_TX;
            KIND_VAR_RSP:  tx_slot = CNT_VRSP_TX;
            KIND_VENDOR:   tx_slot = CNT_VENDOR_TX;
            default:       tx_slot = CNT_ALL_TX;
        endcase
    endfunction

    function automatic logic [3:0] rx_slot(input logic [2:0] k,
                                           input logic d);
        case (k)
            KIND_INFO:     rx_slot = CNT_INFO_RX;
            KIND_EVENT:    rx_slot = d ? CNT_DEVENT_RX : CNT_UEVENT_RX;
            KIND_LOOPBACK: rx_slot = CNT_LOOP_RX;
            KIND_VAR_REQ:  rx_slot = CNT_VREQ_RX;
            KIND_VAR_RSP:  rx_slot = CNT_VRSP_RX;
            KIND_VENDOR:   rx_slot = CNT_VENDOR_RX;
            default:       rx_slot = CNT_UNSUP_RX;
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [1:0][1:0] role;
        logic [1:0][47:0] peer_mac;
        logic [3:0] lost;
        logic [3:0] sel_lost;
        logic [1:0] tx_req;
        next_st = st;
        role = {i_fiber_oam_role_1, i_fiber_oam_role_0};
        peer_mac = {i_peer_mac_1, i_peer_mac_0};
        lost = ~i_link_up;
        sel_lost = 4'h0;
        tx_req = i_oam_tx_req;

        // Staged matrix edits; live copy changes only on confirm or matrix reset.
        if (i_edit_we) begin
            next_st.edit_sel[i_edit_row] = i_edit_sel;
            next_st.edit_or[i_edit_row] = i_edit_or;
        end
        if (i_matrix_reset) begin
            next_st.edit_sel = {4{RST_MATRIX_SEL}};
            next_st.edit_or = {4{RST_ROW_OR}};
            next_st.sel = {4{RST_MATRIX_SEL}};
            next_st.row_or = {4{RST_ROW_OR}};
        end else if (i_matrix_confirm) begin
            next_st.sel = next_st.edit_sel;
            next_st.row_or = next_st.edit_or;
        end

        for (int r = 0; r < NUM_PORTS; r++) begin
            logic any_l;
            logic all_l;
            any_l = |(st.sel[r] & lost);
            all_l = (st.sel[r] & lost) == st.sel[r];
            sel_lost[r] = (st.sel[r] != 4'h0) &&
                          (st.row_or[r] ? any_l : all_l);
        end

        // Pass-through: copper ports are 2 and 3.
        next_st.copper_up_q = i_link_up[3:2];
        next_st.notify_tx = 2'h0;
        next_st.notify_port = st.notify_port;
        for (int c = 0; c < 2; c++) begin
            if (i_remote_pass_select != PASS_OFF &&
                    st.copper_up_q[c] && !i_link_up[c+2]) begin
                next_st.notify_tx[i_remote_pass_select == PASS_FIBER2] = 1'b1;
                next_st.notify_port[i_remote_pass_select == PASS_FIBER2] =
                    1'(c);
            end
        end
        for (int f = 0; f < NUM_FIBER; f++) begin
            if (i_pass_notify_rx[f] && role[f] != ROLE_DISABLED) begin
                next_st.remote_down[i_pass_notify_port] = 1'b1;
            end
        end
        for (int c = 0; c < 2; c++) begin
            if (i_link_up[c+2] && st.remote_down[c] &&
                    !(|i_pass_notify_rx)) begin
                next_st.remote_down[c] = 1'b0;
            end
        end
        if (i_remote_pass_select != PASS_OFF) begin
            next_st.force_down = {st.remote_down, 2'h0};
        end else begin
            next_st.remote_down = 2'h0;
            next_st.force_down = sel_lost;
        end

        // OAM role resolution and frame pacing, fiber ports only.
        next_st.grant = 2'h0;
        next_st.tx_kind = i_oam_tx_kind;
        for (int f = 0; f < NUM_FIBER; f++) begin
            next_st.act_active[f] = (role[f] == ROLE_ACTIVE) &&
                (!i_peer_active[f] || i_local_mac < peer_mac[f]);
            next_st.adopt[f] = (role[f] != ROLE_DISABLED) &&
                !next_st.act_active[f];
            if (st.gap[f] != 32'h0) begin
                next_st.gap[f] = st.gap[f] - 32'h1;
            end else if (tx_req[f] && role[f] != ROLE_DISABLED) begin
                next_st.grant[f] = 1'b1;
                next_st.gap[f] = OAM_GAP - 32'h1;
            end
        end

        // Seconds tick drives stats sampling and address aging.
        next_st.sample = 1'b0;
        next_st.hit = st.hit;
        if (st.sec_cnt == SEC - 32'h1) begin
            next_st.sec_cnt = 32'h0;
            next_st.sample_sec = st.sample_sec + 2'h1;
            if (st.sample_sec == 2'(SAMPLE_S - 1)) begin
                next_st.sample_sec = 2'h0;
                next_st.sample = 1'b1;
            end
            next_st.age_sec = st.age_sec + 9'h1;
            if (st.age_sec == 9'(AGE_TIME_S - 1)) begin
                next_st.age_sec = 9'h0;
                next_st.valid = st.valid & (st.hit | st.is_static);
                next_st.hit = 16'h0;
            end
        end else begin
            next_st.sec_cnt = st.sec_cnt + 32'h1;
        end

        next_st.learn_en = i_learn_enable;
        if (i_clear_dynamic) begin
            next_st.valid = next_st.valid & st.is_static;
        end
        if (i_learn_req && (st.learn_en || i_learn_static)) begin
            next_st.valid[i_learn_idx] = 1'b1;
            next_st.is_static[i_learn_idx] = i_learn_static;
            next_st.hit[i_learn_idx] = 1'b1;
        end

        next_st.oam_count = oam_cnt[i_cnt_fiber][i_cnt_sel];
        next_st.rx_count = rx_cnt[i_port_sel];
        next_st.tx_count = tx_cnt[i_port_sel];
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st <= '0;
            st.learn_en <= RST_LEARN_EN;
        end else begin
            st <= next_st;
        end
    end

    assign o_port_force_down  = st.force_down;
    assign o_oam_tx_grant     = st.grant;
    assign o_oam_tx_kind      = st.tx_kind;
    assign o_oam_act_active   = st.act_active;
    assign o_adopt_peer_cfg   = st.adopt;
    assign o_pass_notify_tx   = st.notify_tx;
    assign o_pass_notify_port = st.notify_port;
    assign o_oam_count        = st.oam_count;
    assign o_rx_count         = st.rx_count;
    assign o_tx_count         = st.tx_count;
    assign o_stats_sample     = st.sample;
    assign o_entry_valid      = st.valid;
    assign o_entry_static     = st.is_static;
    assign o_learn_enabled    = st.learn_en;

endmodule // link_fault_oam_stats
`default_nettype wire

// [verification/fault_checker_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module fault_checker
    import fault_stats_pkg::*;
#(
    parameter int unsigned OAM_GAP = 10,
    parameter int unsigned SEC     = 4
) (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic [3:0]  i_link_up,
    input wire logic [1:0]  i_remote_pass_select,
    input wire logic [1:0]  i_fiber_oam_role_0,
    input wire logic [1:0]  i_fiber_oam_role_1,
    input wire logic [47:0] i_local_mac,
    input wire logic [1:0]  i_peer_active,
    input wire logic [47:0] i_peer_mac_0,
    input wire logic [47:0] i_peer_mac_1,
    input wire logic [1:0]  i_oam_tx_req,
    input wire logic        i_clear_counters,
    input wire logic        i_learn_enable,
    input wire logic [3:0]  o_port_force_down,
    input wire logic [1:0]  o_oam_tx_grant,
    input wire logic [1:0]  o_oam_act_active,
    input wire logic [1:0]  o_adopt_peer_cfg,
    input wire logic [1:0]  o_pass_notify_tx,
    input wire logic [31:0] o_oam_count,
    input wire logic [63:0] o_rx_count,
    input wire logic        o_stats_sample,
    input wire logic        o_learn_enabled
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    int unsigned gap_cnt;
    int unsigned smp_cnt;
    logic        smp_seen;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            gap_cnt  <= OAM_GAP;
            smp_cnt  <= 0;
            smp_seen <= 1'b0;
        end else begin
            gap_cnt  <= o_oam_tx_grant[0] ? 0 : gap_cnt + 1;
            smp_cnt  <= o_stats_sample ? 0 : smp_cnt + 1;
            smp_seen <= smp_seen | o_stats_sample;
        end
    end

    sequence s_low_active;
        i_fiber_oam_role_0 == ROLE_ACTIVE && i_peer_active[0]
            && i_local_mac < i_peer_mac_0;
    endsequence
    sequence s_high_active;
        i_fiber_oam_role_1 == ROLE_ACTIVE && i_peer_active[1]
            && i_local_mac > i_peer_mac_1;
    endsequence
    sequence s_copper_drop;
        i_remote_pass_select == PASS_FIBER1 && $fell(i_link_up[2]);
    endsequence

    property p_low_wins;
        s_low_active |=> o_oam_act_active[0];
    endproperty
    a_low_wins: assert property (p_low_wins) else $error("low mac not active");
    property p_high_yields;
        s_high_active |=> !o_oam_act_active[1] && o_adopt_peer_cfg[1];
    endproperty
    a_high_yields: assert property (p_high_yields) else $error("high mac not passive");
    property p_gap;
        o_oam_tx_grant[0] |-> gap_cnt >= OAM_GAP - 1;
    endproperty
    a_gap: assert property (p_gap) else $error("oam grants too close");
    property p_grant_req;
        o_oam_tx_grant[0] |-> $past(i_oam_tx_req[0]);
    endproperty
    a_grant_req: assert property (p_grant_req) else $error("grant without request");
    property p_disabled;
        i_fiber_oam_role_1 == ROLE_DISABLED |=> !o_oam_tx_grant[1];
    endproperty
    a_disabled: assert property (p_disabled) else $error("grant on disabled fiber");
    property p_notify;
        s_copper_drop |-> ##[1:2] o_pass_notify_tx[0];
    endproperty
    a_notify: assert property (p_notify) else $error("no notification sent");
    property p_release;
        i_remote_pass_select == PASS_OFF && i_link_up == 4'hf
            |=> o_port_force_down == 4'h0;
    endproperty
    a_release: assert property (p_release) else $error("port held down");
    property p_clear;
        i_clear_counters |-> ##2 (o_oam_count == 32'h0 && o_rx_count == 64'h0);
    endproperty
    a_clear: assert property (p_clear) else $error("counters not cleared");
    property p_sample;
        o_stats_sample |-> !smp_seen || smp_cnt == 3 * SEC - 1;
    endproperty
    a_sample: assert property (p_sample) else $error("sample period wrong");
    property p_learn_off;
        !i_learn_enable |=> !o_learn_enabled;
    endproperty
    a_learn_off: assert property (p_learn_off) else $error("learning stays on");
endmodule // fault_checker

bind link_fault_oam_stats fault_checker #(.OAM_GAP(OAM_GAP), .SEC(SEC)) chk_i (.*);
`default_nettype wire

// [verification/peer_model.sv]
`timescale 1ns/10ps
`default_nettype none
module peer_model
    import fault_stats_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [1:0] i_grant,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_send,
    input  wire logic [0:0] i_send_fiber,
    input  wire logic [2:0] i_send_kind,
    input  wire logic       i_send_dup,
    output logic      [1:0] o_rx,
    output logic      [2:0] o_rx_kind,
    output logic            o_rx_dup
);
    logic [4:0] wait_c [2];

    initial begin
        o_rx = 2'h0;
        o_rx_kind = 3'h0;
        o_rx_dup = 1'b0;
        wait_c = '{5'h0, 5'h0};
    end
    always @(posedge i_clk) begin
        o_rx <= 2'h0;
        o_rx_kind <= ~o_rx_kind;
        o_rx_dup <= ~o_rx_dup;
        for (int f = 0; f < 2; f++) begin
            if (i_grant[f]) begin
                wait_c[f] <= 5'(i_delay) + 5'(f * 6) + 5'h1;
            end else if (wait_c[f] == 5'h1) begin
                o_rx[f] <= 1'b1;
                o_rx_kind <= KIND_INFO;
                o_rx_dup <= 1'b0;
                wait_c[f] <= 5'h0;
            end else if (wait_c[f] != 5'h0) begin
                wait_c[f] <= wait_c[f] - 5'h1;
            end
        end
        if (i_send) begin
            o_rx <= 2'h1 << i_send_fiber;
            o_rx_kind <= i_send_kind;
            o_rx_dup <= i_send_dup;
        end
    end
endmodule // peer_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fault_stats_pkg::*;
    localparam int unsigned GAP  = 10;
    localparam int unsigned SECS = 4;
    typedef struct { int id; logic [63:0] v; } note_t;
    logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_edit_or = 1'b0;
    logic        i_edit_we = 1'b0, i_matrix_confirm = 1'b0;
    logic        i_matrix_reset = 1'b0, i_pass_notify_port = 1'b0;
    logic [3:0]  i_link_up = 4'hf, i_edit_sel_row = 4'h0, i_edit_sel = 4'h0;
    logic [1:0]  i_edit_row = 2'h0, i_remote_pass_select = PASS_OFF;
    logic [1:0]  i_fiber_oam_role_0 = ROLE_ACTIVE, i_port_sel = 2'h0;
    logic [1:0]  i_fiber_oam_role_1 = ROLE_ACTIVE, i_peer_active = 2'h0;
    logic [1:0]  i_oam_tx_req = 2'h0, i_pass_notify_rx = 2'h0, i_oam_rx;
    logic [47:0] i_local_mac = 48'h0, i_peer_mac_0 = 48'h0;
    logic [47:0] i_peer_mac_1 = 48'h0;
    logic [2:0]  i_oam_tx_kind = 3'h0, i_oam_rx_kind, snd_kind = 3'h0;
    logic        i_oam_rx_dup, snd = 1'b0, snd_dup = 1'b0;
    logic [0:0]  i_cnt_fiber = 1'b0, snd_fiber = 1'b1;
    logic [3:0]  i_frame_rx = 4'h0, i_frame_tx = 4'h0, i_learn_idx = 4'h0;
    logic [3:0]  i_cnt_sel = 4'h0, o_port_force_down;
    logic        i_clear_counters = 1'b0, i_learn_enable = 1'b1;
    logic        i_learn_req = 1'b0, i_learn_static = 1'b0;
    logic        i_clear_dynamic = 1'b0, o_stats_sample, o_learn_enabled;
    logic [1:0]  o_oam_tx_grant, o_oam_act_active, o_adopt_peer_cfg;
    logic [1:0]  o_pass_notify_tx, o_pass_notify_port;
    logic [2:0]  o_oam_tx_kind;
    logic [31:0] o_oam_count;
    logic [63:0] o_rx_count, o_tx_count, seen;
    logic [15:0] o_entry_valid, o_entry_static;
    logic [3:0]  slot [8] = '{CNT_INFO_RX, CNT_UEVENT_RX, CNT_LOOP_RX,
        CNT_VREQ_RX, CNT_VRSP_RX, CNT_VENDOR_RX, CNT_UNSUP_RX, CNT_DEVENT_RX};
    string       nm [10] = '{"force", "active", "adopt", "notify", "oam",
        "rx", "tx", "valid", "static", "learn"};
    note_t       q [$];
    logic        look = 1'b0;
    int          n_errors = 0, checked = 0, seed = 41, w, p, n;

    link_fault_oam_stats #(.OAM_GAP(GAP), .SEC(SECS)) link_fault_oam_stats_i (.*);
    peer_model peer_model_i (.i_clk(i_clk), .i_grant(o_oam_tx_grant),
        .i_delay(4'h2), .i_send(snd), .i_send_fiber(snd_fiber),
        .i_send_kind(snd_kind), .i_send_dup(snd_dup), .o_rx(i_oam_rx),
        .o_rx_kind(i_oam_rx_kind), .o_rx_dup(i_oam_rx_dup));

    always #2.5 i_clk = ~i_clk;

    task automatic cyc(int k);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic note(int id, logic [63:0] v);
        q.push_back('{id, v});
        look = 1'b1;
        cyc(1);
        look = 1'b0;
    endtask
    task automatic strobe(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic lk(logic [3:0] v);
        i_link_up = v;
        cyc(1);
    endtask
    task automatic edit(logic [1:0] r, logic [3:0] s, logic o);
        {i_edit_row, i_edit_sel, i_edit_or, i_edit_we} = {r, s, o, 1'b1};
        cyc(1);
        i_edit_we = 1'b0;
    endtask
    task automatic rd(logic f, logic [3:0] s, logic [63:0] e);
        {i_cnt_fiber, i_cnt_sel} = {f, s};
        cyc(3);
        note(4, e);
    endtask
    task automatic cmp(note_t t, logic [63:0] s);
        checked++;
        if (s !== t.v) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm[t.id], t.v, s);
        end
    endtask
    task conclude;
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge i_clk) begin
        if (look) begin
            case (q[0].id)
                0: seen = 64'(o_port_force_down);
                1: seen = 64'(o_oam_act_active);
                2: seen = 64'(o_adopt_peer_cfg);
                3: seen = 64'(o_pass_notify_tx);
                4: seen = 64'(o_oam_count);
                5: seen = o_rx_count;
                6: seen = o_tx_count;
                7: seen = 64'(o_entry_valid);
                8: seen = 64'(o_entry_static);
                default: seen = 64'(o_learn_enabled);
            endcase
            cmp(q.pop_front(), seen);
        end
    end

    initial begin
        cyc(16);
        i_sys_rst = 1'b0;
        cyc(2);
        note(9, 64'h1);
        note(0, 64'h0);
        i_local_mac = {2'h1, 46'($random(seed))};
        i_peer_mac_0 = {2'h2, 46'($random(seed))};
        i_peer_mac_1 = {2'h0, 46'($random(seed))};
        i_peer_active = 2'h3;
        cyc(2);
        note(1, 64'h1);
        note(2, 64'h2);
        for (int m = 0; m < 2; m++) begin
            edit(2'h0, 4'h6, m[0]);
            edit(2'h1, 4'h8, m[0]);
            lk(4'hd);
            note(0, 64'h0);
            i_link_up = 4'hf;
            strobe(i_matrix_confirm);
            lk(4'hd);
            note(0, 64'(m));
            lk(4'h1);
            note(0, 64'h3);
            lk(4'hf);
            note(0, 64'h0);
        end
        i_link_up = 4'hd;
        strobe(i_matrix_reset);
        note(0, 64'h0);
        edit(2'h0, 4'h4, 1'b0);
        strobe(i_matrix_confirm);
        i_remote_pass_select = PASS_FIBER1;
        lk(4'h3);
        note(3, 64'h1);
        note(0, 64'h0);
        {i_pass_notify_rx, i_pass_notify_port} = 3'h3;
        cyc(1);
        i_pass_notify_rx = 2'h0;
        cyc(1);
        note(0, 64'h8);
        i_link_up = 4'hf;
        cyc(2);
        i_remote_pass_select = PASS_OFF;
        strobe(i_matrix_reset);
        i_fiber_oam_role_1 = ROLE_DISABLED;
        i_oam_tx_kind = 3'($unsigned($random(seed)) % 6);
        i_oam_tx_req = 2'h3;
        cyc(25);
        i_oam_tx_req = 2'h0;
        cyc(20);
        rd(1'b0, CNT_ALL_TX, 64'h3);
        rd(1'b0, CNT_INFO_RX, 64'h3);
        rd(1'b1, CNT_ALL_TX, 64'h0);
        i_fiber_oam_role_1 = ROLE_ACTIVE;
        for (int k = 0; k < 8; k++) begin
            snd_kind = (k == 7) ? KIND_EVENT : 3'(k);
            snd_dup = (k == 7);
            strobe(snd);
            rd(1'b1, slot[k], 64'h1);
        end
        rd(1'b1, CNT_ALL_RX, 64'h8);
        p = $unsigned($random(seed)) % 4;
        n = 1 + $unsigned($random(seed)) % 8;
        i_port_sel = 2'(p);
        repeat (n) begin
            i_frame_rx = 4'h1 << p;
            cyc(1);
        end
        i_frame_rx = 4'h0;
        i_frame_tx = 4'hf;
        cyc(1);
        i_frame_tx = 4'h0;
        cyc(3);
        note(5, 64'(n));
        note(6, 64'h1);
        strobe(i_clear_counters);
        cyc(1);
        note(5, 64'h0);
        note(4, 64'h0);
        for (w = 0; w < 40 && o_stats_sample !== 1'b1; w++) cyc(1);
        if (w == 40) begin
            n_errors++;
            conclude();
        end
        {i_learn_idx, i_learn_static} = 5'h6;
        strobe(i_learn_req);
        {i_learn_idx, i_learn_static} = 5'hb;
        strobe(i_learn_req);
        note(7, 64'h28);
        note(8, 64'h20);
        i_learn_enable = 1'b0;
        strobe(i_clear_dynamic);
        note(7, 64'h20);
        {i_learn_idx, i_learn_static} = 5'h6;
        strobe(i_learn_req);
        i_learn_enable = 1'b1;
        note(9, 64'h0);
        note(7, 64'h20);
        strobe(i_learn_req);
        note(7, 64'h28);
        cyc(600 * SECS + 20);
        note(7, 64'h20);
        cyc(1);
        conclude();
    end
endmodule // tb
`default_nettype wire
